// ===== hw/ccsr_core_state.sv
// ccsr_core_state: register file, flag byte, stack top, pointers and vector selection
// assumes: the execution unit issues at most one ALU, one pointer, one stack and one
// data-space request per clock, all synchronous to sys_clk
//
// Contract
// - Flag bit 5 holds half carry out of the low nibble.
// - Flag bit 4 equals negative XOR overflow, except after the flag byte is written through the data space.
// - Flag bit 3 holds two's complement overflow.
// - Flag bit 2 set on negative result.
// - Flag bit 1 set on zero result.
// - Flag bit 0 set on carry.
// - Register file offers 8/8, 8+8/8, 8+8/16 and 16/16 access schemes.
// - All 32 registers appear at data addresses 0 to 31.
// - Registers 26..31 form three 16-bit pointers, low byte first.
// - Pointers support displacement, post-increment and pre-decrement.
// - Byte push decrements stack top by one, pop increments by one.
// - Call or interrupt decrements stack top by two; returns increment by two.
// - Stack top is two 8-bit read/write registers resetting to zero.
// - Core runs directly on the chip clock, undivided.
// - Fetch overlaps execute; one instruction completes per clock.
// - Two-operand ALU reads, computes and writes back in one clock.
// - Interrupt serviced only with own enable and global enable set.
// - Boot lock bits disable interrupts depending on program counter.
// - Vectors at lowest addresses; lower address wins; reset highest.
// - Vector move bit relocates interrupt vectors to boot section start.
// - Boot entry fuse relocates reset vector to boot section start.
// - Bit 7 global enable cleared on interrupt entry, set by handler exit.
// - Bit 6 is the bit copy storage for bit store and load.
`timescale 1ns/1ns
module ccsr_core_state #(
   parameter int          NUM_IRQ    = 8,        // interrupt sources, index 0 highest
   parameter logic [15:0] BOOT_START = 16'h1C00  // boot section start, word address
) (
   input  wire logic                     sys_clk,            // core clock, undivided
   input  wire logic                     rst_n,              // async reset, active low
   input  wire ccsr_pkg::ccsr_alu_req_t  alu_req,            // register ALU request
   input  wire ccsr_pkg::ccsr_ptr_req_t  ptr_req,            // pointer addressing request
   input  wire ccsr_pkg::ccsr_stk_t      stk_op,             // stack adjustment
   input  wire ccsr_pkg::ccsr_data_req_t data_req,           // data space access, low map
   input  wire logic [NUM_IRQ-1:0]       irq_pending,        // source flags
   input  wire logic [NUM_IRQ-1:0]       irq_enable,         // per-source enables
   input  wire logic                     irq_ack,            // interrupt entry taken
   input  wire logic                     boot_section_lock_a,// lock for application area
   input  wire logic                     boot_section_lock_b,// lock for boot area
   input  wire logic                     boot_entry_fuse,    // programmed = reset in boot
   input  wire logic [15:0]              pc,                 // current program counter
   output logic [7:0]                    flag_byte,          // flag byte
   output logic [15:0]                   stack_top,          // stack pointer
   output logic [15:0]                   ptr_addr,           // effective pointer address
   output logic [7:0]                    data_rdata,         // data space read value
   output logic                          data_hit,           // address decoded here
   output logic                          irq_req,            // interrupt wanted
   output logic [15:0]                   irq_vector,         // vector of highest source
   output logic [15:0]                   reset_vector        // reset vector address
);
   typedef struct packed {
      logic [ccsr_pkg::NUM_REGS-1:0][7:0] gpr;
      logic [7:0]                         flags;
      logic [7:0]                         stack_top_high;
      logic [7:0]                         stack_top_low;
      logic [7:0]                         core_control_reg;
      logic [15:0]                        ptr_addr;
      logic [7:0]                         rdata;
      logic                               hit;
      logic                               irq;
      logic [15:0]                        vec;
      logic [15:0]                        rvec;
   } ccsr_state_t;

   ccsr_state_t state_reg;
   ccsr_state_t state_next;

   logic [15:0] alu_res;
   logic        alu_wide;
   logic        alu_wr;
   logic [7:0]  alu_flags;
   logic [4:0]  plo;
   logic [15:0] pval;
   logic [15:0] sp;
   logic        lock_block;
   logic [NUM_IRQ-1:0] live;
   logic [15:0] vbase;

   // ==========================================
   // ALU: operands leave and result returns in the same clock
   ccsr_alu u_alu (
      .op      (alu_req.op),
      .a       (state_reg.gpr[alu_req.dst]),
      .b       (state_reg.gpr[alu_req.src]),
      .w       ({state_reg.gpr[alu_req.dst + 5'd1], state_reg.gpr[alu_req.dst]}),
      .imm     ((alu_req.op == ccsr_pkg::CCSR_OP_BST || alu_req.op == ccsr_pkg::CCSR_OP_BLD)
                ? {3'h0, alu_req.bitsel} : alu_req.imm),
      .flags   (state_reg.flags),
      .res     (alu_res),
      .wide    (alu_wide),
      .wr      (alu_wr),
      .flags_o (alu_flags)
   );

   // ==========================================
   // next state
   always_comb begin
      state_next = state_reg;
      // register ALU write back, one clock, no stall
      if (alu_wr) begin
         if (alu_wide && alu_req.op == ccsr_pkg::CCSR_OP_MUL) begin
            // product lands only in r1:r0, the named destination is left alone
            state_next.gpr[0] = alu_res[7:0];
            state_next.gpr[1] = alu_res[15:8];
         end else begin
            state_next.gpr[alu_req.dst] = alu_res[7:0];
            if (alu_wide)
               state_next.gpr[alu_req.dst + 5'd1] = alu_res[15:8];
         end
      end
      state_next.flags = alu_flags;

      // pointer addressing
      case (ptr_req.sel)
         ccsr_pkg::CCSR_PTR_Y: plo = ccsr_pkg::PTR_Y_LO;
         ccsr_pkg::CCSR_PTR_Z: plo = ccsr_pkg::PTR_Z_LO;
         default:              plo = ccsr_pkg::PTR_X_LO;
      endcase
      pval = {state_reg.gpr[plo + 5'd1], state_reg.gpr[plo]};
      if (ptr_req.valid) begin
         case (ptr_req.mode)
            ccsr_pkg::CCSR_AM_POSTINC: begin
               state_next.ptr_addr = pval;
               {state_next.gpr[plo + 5'd1], state_next.gpr[plo]} = pval + 16'h0001;
            end
            ccsr_pkg::CCSR_AM_PREDEC: begin
               state_next.ptr_addr = pval - 16'h0001;
               {state_next.gpr[plo + 5'd1], state_next.gpr[plo]} = pval - 16'h0001;
            end
            default: state_next.ptr_addr = pval + {10'h000, ptr_req.disp};
         endcase
      end

      // stack top
      sp = {state_reg.stack_top_high, state_reg.stack_top_low};
      case (stk_op)
         ccsr_pkg::CCSR_STK_PUSH: sp = sp - ccsr_pkg::STK_STEP_BYTE;
         ccsr_pkg::CCSR_STK_POP:  sp = sp + ccsr_pkg::STK_STEP_BYTE;
         ccsr_pkg::CCSR_STK_CALL: sp = sp - ccsr_pkg::STK_STEP_ADDR;
         ccsr_pkg::CCSR_STK_RET,
         ccsr_pkg::CCSR_STK_HANDLER_EXIT_OP: sp = sp + ccsr_pkg::STK_STEP_ADDR;
         default: sp = sp;
      endcase
      {state_next.stack_top_high, state_next.stack_top_low} = sp;

      // global enable: entry clears, handler exit sets
      if (stk_op == ccsr_pkg::CCSR_STK_HANDLER_EXIT_OP)
         state_next.flags[ccsr_pkg::FLAG_I] = 1'b1;
      if (irq_ack)
         state_next.flags[ccsr_pkg::FLAG_I] = 1'b0;

      // data space window: registers at 0..31, then flag, stack and control I/O
      state_next.hit   = 1'b0;
      state_next.rdata = 8'h00;
      if (data_req.valid) begin
         if (data_req.addr < ccsr_pkg::REGFILE_TOP) begin
            state_next.hit   = 1'b1;
            state_next.rdata = state_reg.gpr[data_req.addr[4:0]];
            if (data_req.wr)
               state_next.gpr[data_req.addr[4:0]] = data_req.wdata;
         end else begin
            case (data_req.addr)
               ccsr_pkg::IO_FLAG_ADDR: begin
                  state_next.hit   = 1'b1;
                  state_next.rdata = state_reg.flags;
                  if (data_req.wr) state_next.flags = data_req.wdata;
               end
               ccsr_pkg::IO_STKH_ADDR: begin
                  state_next.hit   = 1'b1;
                  state_next.rdata = state_reg.stack_top_high;
                  if (data_req.wr) state_next.stack_top_high = data_req.wdata;
               end
               ccsr_pkg::IO_STKL_ADDR: begin
                  state_next.hit   = 1'b1;
                  state_next.rdata = state_reg.stack_top_low;
                  if (data_req.wr) state_next.stack_top_low = data_req.wdata;
               end
               ccsr_pkg::IO_CORE_ADDR: begin
                  state_next.hit   = 1'b1;
                  state_next.rdata = state_reg.core_control_reg;
                  if (data_req.wr) state_next.core_control_reg = data_req.wdata;
               end
               default: state_next.hit = 1'b0;
            endcase
         end
      end

      // interrupt selection: lowest index wins, gated by both enables and lock
      lock_block = (boot_section_lock_a && pc < BOOT_START) ||
                   (boot_section_lock_b && pc >= BOOT_START);
      live = irq_pending & irq_enable;
      vbase = state_reg.core_control_reg[ccsr_pkg::VEC_MOVE_BIT] ? BOOT_START
                                                                 : ccsr_pkg::RESET_VEC;
      state_next.irq = (|live) && state_reg.flags[ccsr_pkg::FLAG_I] && !lock_block;
      state_next.vec = vbase;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (live[i])
            state_next.vec = vbase + ccsr_pkg::VEC_STRIDE * 16'(i + 1);
      end
      state_next.rvec = boot_entry_fuse ? BOOT_START : ccsr_pkg::RESET_VEC;
   end

   // ==========================================
   // state register, on the undivided core clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg                <= '0;
         state_reg.flags          <= ccsr_pkg::FLAG_RESET;
         state_reg.stack_top_high <= ccsr_pkg::STK_RESET;
         state_reg.stack_top_low  <= ccsr_pkg::STK_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flag_byte    = state_reg.flags;
   assign stack_top    = {state_reg.stack_top_high, state_reg.stack_top_low};
   assign ptr_addr     = state_reg.ptr_addr;
   assign data_rdata   = state_reg.rdata;
   assign data_hit     = state_reg.hit;
   assign irq_req      = state_reg.irq;
   assign irq_vector   = state_reg.vec;
   assign reset_vector = state_reg.rvec;

   // ==========================================
   // checks
   sequence seq_call;
      stk_op == ccsr_pkg::CCSR_STK_CALL && !(data_req.valid && data_req.wr);
   endsequence
   sequence seq_push;
      stk_op == ccsr_pkg::CCSR_STK_PUSH && !(data_req.valid && data_req.wr);
   endsequence

   AST_SIGN_XOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($changed(flag_byte[ccsr_pkg::FLAG_N]) || $changed(flag_byte[ccsr_pkg::FLAG_V])) && !$past(data_req.valid)
      |-> flag_byte[ccsr_pkg::FLAG_S] == (flag_byte[ccsr_pkg::FLAG_N] ^ flag_byte[ccsr_pkg::FLAG_V]))
      else $error("sign flag differs from N xor V");
   AST_PUSH_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_push |=> stack_top == $past(stack_top) - 16'h0001)
      else $error("push did not step stack by one");
   AST_CALL_TWO: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seq_call |=> stack_top == $past(stack_top) - 16'h0002)
      else $error("call did not step stack by two");
   AST_RET_TWO: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stk_op == ccsr_pkg::CCSR_STK_RET && !data_req.valid |=> stack_top == $past(stack_top) + 16'h0002)
      else $error("return did not step stack by two");
   AST_HANDLER_EXIT_OP_GIE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stk_op == ccsr_pkg::CCSR_STK_HANDLER_EXIT_OP && !irq_ack && !data_req.valid |=> flag_byte[ccsr_pkg::FLAG_I])
      else $error("handler exit did not set global enable");
   AST_ACK_GIE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq_ack && !data_req.valid |=> !flag_byte[ccsr_pkg::FLAG_I])
      else $error("interrupt entry did not clear global enable");
   AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq_req |-> $past(flag_byte[ccsr_pkg::FLAG_I]) && $past(|(irq_pending & irq_enable)))
      else $error("interrupt raised without both enables");
   AST_POSTINC: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ptr_req.valid && ptr_req.mode == ccsr_pkg::CCSR_AM_POSTINC && ptr_req.sel == ccsr_pkg::CCSR_PTR_X
      && !alu_wr && !data_req.valid
      |=> ptr_addr + 16'h0001 == {state_reg.gpr[27], state_reg.gpr[26]})
      else $error("post-increment pointer wrong");
endmodule : ccsr_core_state

// ===== inc/ccsr_pkg.sv
// ccsr_pkg: constants and carrier types for the core state register block
// assumes: single core clock, byte-wide data space, 16-bit program addresses
package ccsr_pkg;
   // ==========================================
   // flag byte bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // ==========================================
   // data space map
   localparam int          NUM_REGS      = 32;
   localparam logic [15:0] REGFILE_TOP   = 16'h0020;
   localparam logic [4:0]  PTR_X_LO      = 5'h1A;
   localparam logic [4:0]  PTR_Y_LO      = 5'h1C;
   localparam logic [4:0]  PTR_Z_LO      = 5'h1E;
   localparam logic [15:0] IO_FLAG_ADDR  = 16'h005F;
   localparam logic [15:0] IO_STKH_ADDR  = 16'h005E;
   localparam logic [15:0] IO_STKL_ADDR  = 16'h005D;
   localparam logic [15:0] IO_CORE_ADDR  = 16'h0055;
   localparam int          VEC_MOVE_BIT  = 1;
   localparam logic [7:0]  STK_RESET     = 8'h00;
   localparam logic [15:0] STK_STEP_BYTE = 16'h0001;
   localparam logic [15:0] STK_STEP_ADDR = 16'h0002;
   // ==========================================
   // vector placement
   localparam logic [15:0] VEC_STRIDE    = 16'h0001;
   localparam logic [15:0] RESET_VEC     = 16'h0000;
   // ==========================================
   // operations
   typedef enum logic [3:0] {
      CCSR_OP_NONE, CCSR_OP_ADD, CCSR_OP_ADC, CCSR_OP_SUB, CCSR_OP_SBC,
      CCSR_OP_AND, CCSR_OP_OR,  CCSR_OP_XOR, CCSR_OP_MOV, CCSR_OP_MUL,
      CCSR_OP_ADIW, CCSR_OP_BST, CCSR_OP_BLD, CCSR_OP_INC, CCSR_OP_COM
   } ccsr_op_t;
   typedef enum logic [2:0] {
      CCSR_STK_NONE, CCSR_STK_PUSH, CCSR_STK_POP, CCSR_STK_CALL, CCSR_STK_RET, CCSR_STK_HANDLER_EXIT_OP
   } ccsr_stk_t;
   typedef enum logic [1:0] {
      CCSR_PTR_X = 2'h0, CCSR_PTR_Y = 2'h1, CCSR_PTR_Z = 2'h2
   } ccsr_ptr_sel_t;
   typedef enum logic [1:0] {
      CCSR_AM_DISP = 2'h0, CCSR_AM_POSTINC = 2'h1, CCSR_AM_PREDEC = 2'h2
   } ccsr_amode_t;
   typedef struct packed {
      ccsr_op_t   op;
      logic [4:0] dst;
      logic [4:0] src;
      logic [2:0] bitsel;
      logic [5:0] imm;
   } ccsr_alu_req_t;
   typedef struct packed {
      logic          valid;
      ccsr_ptr_sel_t sel;
      ccsr_amode_t   mode;
      logic [5:0]    disp;
   } ccsr_ptr_req_t;
   typedef struct packed {
      logic        valid;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ccsr_data_req_t;
endpackage : ccsr_pkg

// ===== hw/ccsr_alu.sv
// ccsr_alu: combinational ALU producing result and flag updates
// assumes: operands come straight from the register file in the same cycle
`timescale 1ns/1ns
module ccsr_alu (
   input  wire ccsr_pkg::ccsr_op_t op,      // operation
   input  wire logic [7:0]         a,       // destination operand
   input  wire logic [7:0]         b,       // source operand
   input  wire logic [15:0]        w,       // word operand for 16-bit ops
   input  wire logic [5:0]         imm,     // word immediate
   input  wire logic [7:0]         flags,   // current flag byte
   output logic [15:0]             res,     // result, high byte used by 16-bit ops
   output logic                    wide,    // result is 16 bits
   output logic                    wr,      // result written back
   output logic [7:0]              flags_o  // next flag byte
);
   logic [8:0]  s9;
   logic [4:0]  h5;
   logic [16:0] s17;
   logic        cin;
   logic        vv;
   logic        nn;

   always_comb begin
      cin     = flags[ccsr_pkg::FLAG_C];
      res     = 16'h0000;
      wide    = 1'b0;
      wr      = 1'b1;
      flags_o = flags;
      s9      = 9'h000;
      h5      = 5'h00;
      s17     = 17'h00000;
      vv      = 1'b0;
      case (op)
         ccsr_pkg::CCSR_OP_ADD, ccsr_pkg::CCSR_OP_ADC: begin
            s9 = {1'b0, a} + {1'b0, b} + {8'h00, (op == ccsr_pkg::CCSR_OP_ADC) & cin};
            h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == ccsr_pkg::CCSR_OP_ADC) & cin};
            vv = (a[7] == b[7]) && (s9[7] != a[7]);
            res = {8'h00, s9[7:0]};
            flags_o[ccsr_pkg::FLAG_C] = s9[8];
            flags_o[ccsr_pkg::FLAG_H] = h5[4];
         end
         ccsr_pkg::CCSR_OP_SUB, ccsr_pkg::CCSR_OP_SBC: begin
            s9 = {1'b0, a} - {1'b0, b} - {8'h00, (op == ccsr_pkg::CCSR_OP_SBC) & cin};
            h5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, (op == ccsr_pkg::CCSR_OP_SBC) & cin};
            vv = (a[7] != b[7]) && (s9[7] != a[7]);
            res = {8'h00, s9[7:0]};
            flags_o[ccsr_pkg::FLAG_C] = s9[8];
            flags_o[ccsr_pkg::FLAG_H] = h5[4];
         end
         ccsr_pkg::CCSR_OP_AND: res = {8'h00, a & b};
         ccsr_pkg::CCSR_OP_OR:  res = {8'h00, a | b};
         ccsr_pkg::CCSR_OP_XOR: res = {8'h00, a ^ b};
         ccsr_pkg::CCSR_OP_INC: begin
            res = {8'h00, a + 8'h01};
            vv  = (a == 8'h7F);
         end
         ccsr_pkg::CCSR_OP_COM: begin
            res = {8'h00, ~a};
            flags_o[ccsr_pkg::FLAG_C] = 1'b1;
         end
         ccsr_pkg::CCSR_OP_MOV: res = {8'h00, b};
         ccsr_pkg::CCSR_OP_MUL: begin
            res  = {8'h00, a} * {8'h00, b};
            wide = 1'b1;
            flags_o[ccsr_pkg::FLAG_C] = res[15];
         end
         ccsr_pkg::CCSR_OP_ADIW: begin
            s17  = {1'b0, w} + {11'h000, imm};
            res  = s17[15:0];
            wide = 1'b1;
            vv   = ~w[15] & res[15];
            flags_o[ccsr_pkg::FLAG_C] = s17[16];
         end
         ccsr_pkg::CCSR_OP_BST: begin
            wr = 1'b0;
            flags_o[ccsr_pkg::FLAG_T] = a[imm[2:0]];
         end
         ccsr_pkg::CCSR_OP_BLD: begin
            res = {8'h00, a};
            res[imm[2:0]] = flags[ccsr_pkg::FLAG_T];
         end
         default: wr = 1'b0;
      endcase
      if (wr && op != ccsr_pkg::CCSR_OP_MOV && op != ccsr_pkg::CCSR_OP_BLD) begin
         nn = wide ? res[15] : res[7];
         flags_o[ccsr_pkg::FLAG_N] = nn;
         flags_o[ccsr_pkg::FLAG_Z] = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
         flags_o[ccsr_pkg::FLAG_V] = vv;
         flags_o[ccsr_pkg::FLAG_S] = nn ^ vv;
      end else begin
         nn = 1'b0;
      end
   end
endmodule : ccsr_alu

// ===== tb/ccsr_sw_model.sv
// ccsr_sw_model: start-up software that places the stack top before any call
// assumes: the bench routes req onto the data port while busy is high
`timescale 1ns/1ns
module ccsr_sw_model (
   input  wire logic                sys_clk, // core clock
   input  wire logic                rst_n,   // async reset, active low
   input  wire logic                start,   // begin the start-up writes
   output ccsr_pkg::ccsr_data_req_t req,     // data space request
   output logic                     busy     // start-up writes in progress
);
   // ==========================================
   // two byte writes, high then low
   logic [1:0] step_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) step_reg <= 2'h3;
      else if (start) step_reg <= 2'h0;
      else if (step_reg != 2'h3) step_reg <= step_reg + 2'h1;
   end
   assign busy = (step_reg != 2'h3);
   // stack top lands at 0x0200, above the low data area
   assign req = '{step_reg < 2'h2, 1'b1, step_reg[0] ? ccsr_pkg::IO_STKL_ADDR : ccsr_pkg::IO_STKH_ADDR,
                  step_reg[0] ? 8'h00 : 8'h02};
endmodule : ccsr_sw_model

// ===== tb/ccsr_core_state_bench.sv
// ccsr_core_state_bench: self-checking bench, reads back state through the data space
// assumes: ccsr_pkg compiled first, design assertions live in the design
`timescale 1ns/1ns
module ccsr_core_state_bench;
   logic                     sys_clk = 1'b0, rst_n = 1'b0, irq_ack = 1'b0, sw_start = 1'b0, rd_d = 1'b0;
   ccsr_pkg::ccsr_alu_req_t  alu_req = '0;
   ccsr_pkg::ccsr_ptr_req_t  ptr_req = '0;
   ccsr_pkg::ccsr_stk_t      stk_op = ccsr_pkg::CCSR_STK_NONE;
   ccsr_pkg::ccsr_data_req_t tb_req = '0, sw_req, data_req;
   logic [7:0]               irq_pending = '0, irq_enable = '0, flag_byte, data_rdata, a, b, r, fl = '0;
   logic                     data_hit, irq_req, sw_busy, h, v, lock_a = 1'b0, fuse = 1'b0;
   logic [15:0]              stack_top, ptr_addr, irq_vector, reset_vector, s = 16'h0200, p;
   logic [31:0]              rng = 32'h00000061;
   logic [8:0]               exp_q[$];
   logic [15:0]              dl[5] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002, 16'h0002};
   logic [15:0]              pa[3] = '{16'h00FF, 16'h00FF, 16'h0104};
   logic [7:0]               plo[3] = '{8'h00, 8'hFF, 8'hFF};
   int                       error_cnt = 0, cmp_count = 0;
   assign data_req = sw_busy ? sw_req : tb_req;
   initial forever #5 sys_clk = ~sys_clk;
   ccsr_core_state i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .alu_req(alu_req), .ptr_req(ptr_req),
      .stk_op(stk_op), .data_req(data_req), .irq_pending(irq_pending), .irq_enable(irq_enable),
      .irq_ack(irq_ack), .boot_section_lock_a(lock_a), .boot_section_lock_b(1'b0), .boot_entry_fuse(fuse),
      .pc(16'h0000), .flag_byte(flag_byte), .stack_top(stack_top), .ptr_addr(ptr_addr),
      .data_rdata(data_rdata), .data_hit(data_hit), .irq_req(irq_req), .irq_vector(irq_vector),
      .reset_vector(reset_vector));
   ccsr_sw_model i_sw (.sys_clk(sys_clk), .rst_n(rst_n), .start(sw_start), .req(sw_req), .busy(sw_busy));
   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xorshift
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // every request stands for exactly one edge, the next call replaces it
   task automatic put(input ccsr_pkg::ccsr_data_req_t d, input ccsr_pkg::ccsr_stk_t k = ccsr_pkg::CCSR_STK_NONE,
                      input ccsr_pkg::ccsr_alu_req_t al = '0, input ccsr_pkg::ccsr_ptr_req_t p = '0);
      tb_req <= d;
      stk_op <= k;
      alu_req <= al;
      ptr_req <= p;
      @(posedge sys_clk);
   endtask : put
   task automatic rd(input logic [15:0] ad, input logic [7:0] e, input logic hit = 1'b1);
      exp_q.push_back({hit, e});
      put('{1'b1, 1'b0, ad, 8'h00});
   endtask : rd
   // ==========================================
   // result watcher: answer lands one cycle after a read is taken
   always @(posedge sys_clk) begin
      if (rd_d) check("read", {7'h00, data_hit, data_rdata}, {7'h00, exp_q.pop_front()});
      rd_d <= data_req.valid & ~data_req.wr;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(16'h005D, 8'h00);
      rd(16'h005E, 8'h00);
      rd(16'h0040, 8'h00, 1'b0);
      check("reset_vector", reset_vector, 16'h0000);
      put('0);
      sw_start <= 1'b1;
      @(posedge sys_clk);
      sw_start <= 1'b0;
      // busy rises only after this edge settles, so wait at least one edge
      for (int i = 0; i < 10 && (i == 0 || sw_busy !== 1'b0); i++) @(posedge sys_clk);
      if (sw_busy !== 1'b0) begin
         error_cnt++;
         test_done();
      end
      for (int i = 0; i < 5; i++) begin
         put('0, ccsr_pkg::ccsr_stk_t'(i + 1));
         s = s + dl[i];
         rd(16'h005D, s[7:0]);
         check("stack_top", stack_top, s);
         rd(16'h005E, s[15:8]);
      end
      fl[7] = 1'b1;
      rd(16'h005F, fl);
      put('0);
      irq_pending <= 8'h04;
      irq_enable <= 8'h04;
      repeat (2) @(posedge sys_clk);
      check("irq_req", {15'h0000, irq_req}, 16'h0001);
      check("irq_vector", irq_vector, 16'h0003);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      fl[7] = 1'b0;
      repeat (2) @(posedge sys_clk);
      check("irq_req", {15'h0000, irq_req}, 16'h0000);
      // random operands for add: flags worked out bit by bit
      for (int i = 0; i < 6; i++) begin
         rng = xorshift(rng);
         {a, b} = rng[15:0];
         r = {4'h0, a[3:0]} + {4'h0, b[3:0]};
         h = r[4];
         {fl[0], r} = {1'b0, a} + {1'b0, b};
         v = (a[7] == b[7]) && (r[7] != a[7]);
         fl[5:1] = {h, r[7] ^ v, v, r[7], r == 8'h00};
         put('{1'b1, 1'b1, 16'h0010, a});
         put('{1'b1, 1'b1, 16'h0011, b});
         put('0, ccsr_pkg::CCSR_STK_NONE, '{ccsr_pkg::CCSR_OP_ADD, 5'h10, 5'h11, 3'h0, 6'h00});
         rd(16'h0010, r);
         rd(16'h005F, fl);
         put('0, ccsr_pkg::CCSR_STK_NONE, '{ccsr_pkg::CCSR_OP_MUL, 5'h10, 5'h11, 3'h0, 6'h00});
         p = {8'h00, r} * {8'h00, b};
         rd(16'h0000, p[7:0]);
         rd(16'h0001, p[15:8]);
         rd(16'h0010, r);
      end
      put('{1'b1, 1'b1, 16'h001A, 8'hFF});
      put('{1'b1, 1'b1, 16'h001B, 8'h00});
      for (int i = 0; i < 3; i++) begin
         put('0, ccsr_pkg::CCSR_STK_NONE, '0,
             '{1'b1, ccsr_pkg::CCSR_PTR_X, ccsr_pkg::ccsr_amode_t'(2'((i + 1) % 3)), 6'h05});
         rd(16'h001A, plo[i]);
         check("ptr_addr", ptr_addr, pa[i]);
      end
      // software sets the global enable, then the boot lock must mask the request
      put('{1'b1, 1'b1, 16'h005F, 8'h80});
      put('0);
      put('0);
      check("irq_req", {15'h0000, irq_req}, 16'h0001);
      lock_a <= 1'b1;
      put('0);
      put('0);
      check("irq_req", {15'h0000, irq_req}, 16'h0000);
      put('{1'b1, 1'b1, 16'h0055, 8'h02});
      rd(16'h0055, 8'h02);
      fuse <= 1'b1;
      put('0);
      check("irq_vector", irq_vector, 16'h1C03);
      put('0);
      check("reset_vector", reset_vector, 16'h1C00);
      put('0);
      repeat (2) @(posedge sys_clk);
      test_done();
   end
endmodule : ccsr_core_state_bench
